// *** dv/clock_source_model.sv ***
`timescale 1ns/1ps
// oscillator and loop stand-in: reports lock a few cycles after enable
module clock_source_model #(
  parameter int LOCK_CYCLES = 4
) (
  // clock and enable
  input  wire logic clock_i,
  input  wire logic main_clock_en_i,
  // lock status
  output logic      locked_o
);
  logic [7:0] count_reg = 8'h00;
  logic [2:0] hold_reg  = 3'h0;
  // reference keeps running a few cycles after stop, so lock lingers
  always_ff @(posedge clock_i) begin
    if (main_clock_en_i) begin
      hold_reg <= 3'h4;
      if (count_reg != 8'(LOCK_CYCLES)) begin
        count_reg <= count_reg + 8'h01;
      end
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end else begin
      count_reg <= 8'h00;
    end
  end
  assign locked_o = (count_reg == 8'(LOCK_CYCLES));
endmodule // clock_source_model

// *** dv/main_clock_ctrl_sva.sv ***
`timescale 1ns/1ps
module main_clock_ctrl_sva
  import clock_reset_pkg::*;
(
  // clock and resets
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       power_on_reset_i,
  input  wire logic       ext_reset_low_pin_i,
  // register access
  input  reg_access_s     access_i,
  input  wire logic [7:0] rdata_o,
  // status in
  input  wire logic       osc_locked_i,
  input  wire logic [7:0] mic_level_i,
  // steering out
  input  clock_cfg_s      clock_cfg_o,
  input  wire logic       audio_reset_o,
  input  wire logic       device_reset_o,
  input  wire logic       irq_low_o,
  input  wire logic       irq_low_oe_o
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic       run;
  logic       cmd_wr;
  logic [6:0] setup_view;
  // the other two reset sources gate every register-access antecedent
  assign run = ext_reset_low_pin_i && !power_on_reset_i;
  assign cmd_wr = run && access_i.write && (access_i.addr == ADDR_COMMAND);
  assign setup_view = {clock_cfg_o.rate_select, clock_cfg_o.loop_ref_frame_sync,
                       clock_cfg_o.loop_closed, clock_cfg_o.use_osc_out, clock_cfg_o.pre_divider};

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  AST_OTHER_RESET: assert property (
    !run |=> audio_reset_o && !clock_cfg_o.main_clock_en && !irq_low_oe_o)
    else $error("reset source left clock state alive");
  AST_START_CMD: assert property (
    cmd_wr && access_i.wdata == CMD_CLOCK_START |=> clock_cfg_o.main_clock_en)
    else $error("start command did not enable clock");
  AST_START_SETTLE: assert property (
    cmd_wr && access_i.wdata == CMD_CLOCK_START && audio_reset_o && !clock_cfg_o.main_clock_en
    |=> audio_reset_o [*8])
    else $error("clock ready before settle time");
  AST_STOP_CMD: assert property (
    cmd_wr && access_i.wdata == CMD_CLOCK_STOP |=> audio_reset_o ##[0:3] !clock_cfg_o.main_clock_en)
    else $error("clock not halted within four cycles");
  AST_AUDIO_HELD: assert property (!audio_reset_o |-> clock_cfg_o.main_clock_en)
    else $error("audio released with clock stopped");
  AST_SETUP_LOCK: assert property (
    run && clock_cfg_o.main_clock_en && !audio_reset_o |=> $stable(setup_view))
    else $error("setup changed while clock running");
  AST_SETUP_READ: assert property (
    run && access_i.read && !access_i.write && access_i.addr == ADDR_CLOCK_SETUP
    |=> rdata_o == {1'b0, $past(setup_view)})
    else $error("setup read data wrong");
  AST_DIV_RANGE: assert property (
    clock_cfg_o.ref_divide_value != 14'h0000 && clock_cfg_o.ref_divide_value <= DIV_ZERO_VALUE
    && clock_cfg_o.feedback_divide_value != 14'h0000
    && clock_cfg_o.feedback_divide_value <= DIV_ZERO_VALUE)
    else $error("divide value out of range");
  AST_IRQ_CLEAR: assert property (
    (run && access_i.read && access_i.addr == ADDR_IRQ_STATUS && !audio_reset_o
     && mic_level_i == 8'h00) ##1 (mic_level_i == 8'h00) |-> ##[1:2] !irq_low_oe_o)
    else $error("status read did not clear interrupt");
  AST_IRQ_VALUE: assert property (irq_low_oe_o |-> !irq_low_o)
    else $error("interrupt pin driven high");
  AST_DEVICE_RESET: assert property (device_reset_o == !run)
    else $error("combined reset does not follow its sources");
  AST_STOP_HOLD: assert property (
    cmd_wr && access_i.wdata == CMD_CLOCK_STOP && clock_cfg_o.main_clock_en
    |=> audio_reset_o [*3])
    else $error("audio released during clock stop");
endmodule // main_clock_ctrl_sva

// *** dv/tb_main_clock_ctrl.sv ***
`timescale 1ns/1ps
module tb_main_clock_ctrl
  import clock_reset_pkg::*;
;
  logic        clock_i           = 1'b0;
  logic        rst_i             = 1'b1;
  logic        power_on_reset    = 1'b0;
  logic        ext_reset_low_pin = 1'b1;
  reg_access_s access            = '0;
  logic [7:0]  mic_level         = 8'h00;
  logic [7:0]  rdata;
  logic        locked;
  clock_cfg_s  cfg;
  logic        audio_reset;
  logic        irq_low;
  logic        irq_low_oe;
  logic        device_reset;
  int          errors            = 0;
  int          total_checks      = 0;
  logic [7:0]  div_hi [3]        = '{8'h00, 8'h1F, 8'hE0};
  logic [7:0]  div_lo [3]        = '{8'h00, 8'hFF, 8'h01};
  logic [15:0] div_exp [3]       = '{16'h2000, 16'h1FFF, 16'h0001};

  always #10 clock_i = ~clock_i;

  main_clock_ctrl i_dut (
    .clock_i(clock_i), .rst_i(rst_i), .power_on_reset_i(power_on_reset),
    .ext_reset_low_pin_i(ext_reset_low_pin), .access_i(access), .rdata_o(rdata),
    .osc_locked_i(locked), .mic_level_i(mic_level), .clock_cfg_o(cfg),
    .audio_reset_o(audio_reset), .device_reset_o(device_reset), .irq_low_o(irq_low),
    .irq_low_oe_o(irq_low_oe)
  );
  clock_source_model #(.LOCK_CYCLES(4)) i_clk_src (
    .clock_i(clock_i), .main_clock_en_i(cfg.main_clock_en), .locked_o(locked)
  );

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  // each access waits an edge first, so strobes never toggle twice at once
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock_i);
    #1 access = '{1'b1, 1'b0, addr, data};
    @(posedge clock_i);
    #1 access = '0;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rdc(input string name, input logic [7:0] addr, input logic [7:0] exp);
    @(posedge clock_i);
    #1 access = '{1'b0, 1'b1, addr, 8'h00};
    @(posedge clock_i);
    #1 access.read = 1'b0;
    chk(name, 16'(exp), 16'(rdata));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // bounded wait for audio release, returns edges taken
  task automatic wait_ready(output int n);
    n = 0;
    while (audio_reset !== 1'b0 && n < 60) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    int n;
    cyc(2);
    rst_i = 1'b0;
    rdc("setup_rst", ADDR_CLOCK_SETUP, RESET_BYTE);
    chk("clk_off", 16'h0001, 16'({cfg.main_clock_en, audio_reset}));
    wr(ADDR_CLOCK_SETUP, 8'h84);
    rdc("setup_b7", ADDR_CLOCK_SETUP, 8'h04);
    chk("osc_mode", 16'h0001, {cfg.loop_closed, cfg.use_osc_out});
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_COMMAND, CMD_CLOCK_START);
    wait_ready(n);
    chk("settle", 16'h0001, 16'(n >= 15 && n <= 20));
    cyc(1);
    chk("irq_rdy", 16'h0001, 16'({irq_low, irq_low_oe}));
    rdc("stat_rdy", ADDR_IRQ_STATUS, 8'h01);
    rdc("stat_clr", ADDR_IRQ_STATUS, 8'h00);
    chk("irq_clr", 16'h0000, 16'(irq_low_oe));
    wr(ADDR_CLOCK_SETUP, 8'h7B);
    rdc("setup_lock", ADDR_CLOCK_SETUP, 8'h04);
    rdc("cmd_active", ADDR_COMMAND, 8'h01);
    wr(ADDR_SYSTEM_ENABLE, 8'h00);
    wr(ADDR_COMMAND, CMD_CLOCK_STOP);
    chk("audio_held", 16'h0001, 16'(audio_reset));
    n = 0;
    while (cfg.main_clock_en !== 1'b0 && n < 8) begin
      cyc(1);
      n++;
    end
    chk("stop_time", 16'h0001, 16'(n <= 3));
    rdc("cmd_idle", ADDR_COMMAND, 8'h00);
    // frame sync reference: the bench plays the slave-port system
    wr(ADDR_CLOCK_SETUP, 8'h7B);
    rdc("setup_open", ADDR_CLOCK_SETUP, 8'h7B);
    chk("fields", 16'h007B, 16'({cfg.rate_select, cfg.loop_ref_frame_sync, cfg.loop_closed,
        cfg.use_osc_out, cfg.pre_divider}));
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_REF_DIV_HIGH, div_hi[i]);
      wr(ADDR_REF_DIV_LOW, div_lo[i]);
      wr(ADDR_FB_DIV_HIGH, div_hi[2 - i]);
      wr(ADDR_FB_DIV_LOW, div_lo[2 - i]);
      chk("ref_div", div_exp[i], 16'(cfg.ref_divide_value));
      chk("fb_div", div_exp[2 - i], 16'(cfg.feedback_divide_value));
    end
    wr(ADDR_LOOP_TUNING, 8'hA5);
    chk("tuning", 16'h00A5, 16'(cfg.loop_tuning));
    rdc("tune_rd", ADDR_LOOP_TUNING, 8'hA5);
    rdc("ref_lo_rd", ADDR_REF_DIV_LOW, 8'h01);
    wr(8'h0E, 8'h55);
    rdc("unmapped", 8'h0E, 8'h00);
    wr(ADDR_LEVEL_THRESH, 8'h10);
    wr(ADDR_IRQ_MASK, 8'h02);
    wr(ADDR_COMMAND, CMD_CLOCK_START);
    wait_ready(n);
    mic_level = 8'h10;
    cyc(3);
    chk("lvl_equal", 16'h0000, 16'(irq_low_oe));
    mic_level = 8'h20;
    cyc(3);
    chk("lvl_over", 16'h0001, 16'(irq_low_oe));
    mic_level = 8'h00;
    rdc("stat_lvl", ADDR_IRQ_STATUS, 8'h03);
    cyc(2);
    chk("lvl_clr", 16'h0000, 16'(irq_low_oe));
    // pin pulse first, then power-on reset, each one microsecond long
    for (int i = 0; i < 2; i++) begin
      power_on_reset = (i == 1);
      ext_reset_low_pin = (i == 1);
      cyc(50);
      chk("rst_dev", 16'h0001, 16'(device_reset));
      power_on_reset = 1'b0;
      ext_reset_low_pin = 1'b1;
      chk("rst_src", 16'h0002, 16'({cfg.main_clock_en, audio_reset, irq_low_oe}));
      rdc("rst_setup", ADDR_CLOCK_SETUP, RESET_BYTE);
      chk("rst_free", 16'h0000, 16'(device_reset));
      wr(ADDR_CLOCK_SETUP, 8'h84);
      wr(ADDR_COMMAND, CMD_CLOCK_START);
      wait_ready(n);
      chk("restart", 16'h0000, 16'(audio_reset));
    end
    summarize();
  end

  // hang guard, about seven times the expected run
  initial begin
    #40000;
    errors++;
    summarize();
  end
endmodule // tb_main_clock_ctrl

bind main_clock_ctrl main_clock_ctrl_sva i_sva (
  .clock_i(clock_i), .rst_i(rst_i), .power_on_reset_i(power_on_reset_i),
  .ext_reset_low_pin_i(ext_reset_low_pin_i), .access_i(access_i), .rdata_o(rdata_o),
  .osc_locked_i(osc_locked_i), .mic_level_i(mic_level_i), .clock_cfg_o(clock_cfg_o),
  .audio_reset_o(audio_reset_o), .device_reset_o(device_reset_o), .irq_low_o(irq_low_o),
  .irq_low_oe_o(irq_low_oe_o)
);

// *** verilog/clock_reset_pkg.sv ***
package clock_reset_pkg;

  // ------------------------------------------------------------------
  // register map (byte-wide registers on the control interface)
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h01;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h02;
  localparam logic [7:0] ADDR_CLOCK_SETUP   = 8'h03;
  localparam logic [7:0] ADDR_REF_DIV_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_REF_DIV_LOW   = 8'h05;
  localparam logic [7:0] ADDR_FB_DIV_HIGH   = 8'h06;
  localparam logic [7:0] ADDR_FB_DIV_LOW    = 8'h07;
  localparam logic [7:0] ADDR_LOOP_TUNING   = 8'h08;
  localparam logic [7:0] ADDR_SYSTEM_ENABLE = 8'h09;
  localparam logic [7:0] ADDR_COMMAND       = 8'h0A;
  localparam logic [7:0] ADDR_LEVEL_THRESH  = 8'h0B;
  localparam logic [7:0] ADDR_MAX           = 8'h0F;

  // ------------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE         = 8'h00;
  localparam logic [7:0] CMD_CLOCK_START    = 8'h01;
  localparam logic [7:0] CMD_CLOCK_STOP     = 8'h00;
  localparam int         POS_RATE_HI        = 6;
  localparam int         POS_RATE_LO        = 5;
  localparam int         POS_LOOP_REF       = 4;
  localparam int         POS_LOOP_MODE      = 3;
  localparam int         POS_MAIN_SOURCE    = 2;
  localparam int         POS_PRE_DIVIDER_HI      = 1;
  localparam int         POS_PRE_DIVIDER_LO      = 0;
  localparam int         POS_IRQ_CLK_READY  = 0;
  localparam int         POS_IRQ_LEVEL      = 1;
  localparam logic [7:0] SETUP_WRITE_MASK   = 8'h7F;
  localparam logic [7:0] DIV_HIGH_MASK      = 8'h1F;
  localparam logic [7:0] IRQ_WRITE_MASK     = 8'h03;
  localparam int         DIV_WIDTH          = 13;
  localparam logic [13:0] DIV_ZERO_VALUE    = 14'h2000;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int         MAIN_CLOCK_KHZ     = 24576;
  localparam int         STOP_MAX_CYCLES    = 4;
  localparam int         START_SETTLE_CYCLES = 16;
  localparam logic [4:0] SETTLE_COUNT       = 5'(START_SETTLE_CYCLES - 1);

  // ------------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CLK_OFF      = 3'b001,
    CLK_STARTING = 3'b010,
    CLK_RUNNING  = 3'b100
  } clk_state_e;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_access_s;

  typedef struct packed {
    logic       main_clock_en;
    logic       use_osc_out;
    logic       loop_closed;
    logic       loop_ref_frame_sync;
    logic [1:0] pre_divider;
    logic [1:0] rate_select;
    logic [13:0] ref_divide_value;
    logic [13:0] feedback_divide_value;
    logic [7:0] loop_tuning;
  } clock_cfg_s;

  // ref/feedback divider fields: zero means the longest divide
  function automatic logic [13:0] divide_ratio(input logic [12:0] field);
    divide_ratio = (field == 13'h0000) ? DIV_ZERO_VALUE : {1'b0, field};
  endfunction

endpackage

// *** verilog/main_clock_ctrl.sv ***
`timescale 1ns/1ps
// Function
// RULE1 - reset from power-on or low reset pin
// RULE2 - host keeps control port idle during reset
// RULE3 - host may pulse reset pin low anytime
// RULE4 - audio registers changed only with clock running
// RULE5 - host starts oscillator first after reset
// RULE6 - logic targets 24.576MHz main clock
// RULE7 - clock off from reset, registers still accessible
// RULE8 - main clock from reference pin or PLL
// RULE9 - frame sync reference only when port slave
// RULE10 - frame sync kept synchronous to reference pin
// RULE11 - host programs setup before clock start
// RULE12 - masked clock-ready drives interrupt pin low
// RULE13 - command 0x01 starts main clock
// RULE14 - ready flag set on ready, read clears
// RULE15 - setup register locked while clock active
// RULE16 - host leaves dividers alone while PLL runs
// RULE17 - host clears enables then sends stop
// RULE18 - clock halts within four cycles of stop
// RULE19 - PLL reference kept four cycles after stop
// RULE20 - audio blocks held in reset while stopped
// RULE21 - oscillator source: audio port, amplifier off
// RULE22 - microphone level over threshold raises interrupt; the code never flags level while the threshold is 0
// RULE23 - setup register bit layout
// RULE24 - loop reference: divided clock or frame sync
// RULE25 - loop mode: open oscillator or closed PLL
// RULE26 - divider zero means divide by 8192
// RULE27 - setup writes ignored while clock active
module main_clock_ctrl
  import clock_reset_pkg::*;
(
  // clock and resets
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       power_on_reset_i,
  input  wire logic       ext_reset_low_pin_i,
  // register access from the control interface
  input  reg_access_s     access_i,
  output logic      [7:0] rdata_o,
  // clock generator status and microphone level
  input  wire logic       osc_locked_i,
  input  wire logic [7:0] mic_level_i,
  // clock steering out
  output clock_cfg_s      clock_cfg_o,
  output logic            audio_reset_o,
  output logic            device_reset_o,
  output logic            irq_low_o,
  output logic            irq_low_oe_o
);

  // ------------------------------------------------------------------
  // reset combination
  // ------------------------------------------------------------------
  // the pin is sampled like any input, so it may be pulled low at any time
  // while powered; a pulse shorter than one clock period can be missed
  logic reset_any;
  assign reset_any = rst_i | power_on_reset_i | ~ext_reset_low_pin_i; // RULE1 RULE3

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    clk_state_e clk_state;
    logic [4:0] settle_count;
    logic [1:0] stop_count;
    logic [7:0] clock_setup;
    logic [7:0] irq_status_reg;
    logic [7:0] irq_mask_reg;
    logic [7:0] system_enable_reg;
    logic [7:0] level_threshold;
    logic       clock_en;
    logic       audio_reset;
  } ctrl_state_s;

  ctrl_state_s state_reg;
  ctrl_state_s state_next;

  logic [15:0][7:0] bank_words;
  logic [7:0]       bank_rdata;
  logic             bank_we;
  logic [7:0]       own_rdata_reg;
  logic [7:0]       own_rdata_next;
  logic             own_hit_reg;
  logic             own_hit_next;
  logic             clock_active;
  logic             level_event;
  logic             ready_event;
  logic             divider_addr;

  // the setup lock and the stop decode both key on this, so a clock that is
  // still settling already counts as active
  assign clock_active = state_reg.clk_state != CLK_OFF;

  // registers reachable with the main clock stopped: this logic runs on
  // the control clock, not the main clock
  assign divider_addr = (access_i.addr >= ADDR_REF_DIV_HIGH)
                      && (access_i.addr <= ADDR_LOOP_TUNING); // RULE7
  assign bank_we = access_i.write && divider_addr;

  // divider and tuning bytes live in the small memory
  reg_bank u_bank (
    .clock_i (clock_i),
    .rst_i   (reset_any),
    .we_i    (bank_we),
    .waddr_i (access_i.addr[3:0]),
    .wdata_i (access_i.wdata),
    .raddr_i (access_i.addr[3:0]),
    .rdata_o (bank_rdata),
    .words_o (bank_words)
  );

  // event sources; ready waits for both the settle count and the lock
  // report, so a lock level left over from a stop cannot cut it short
  assign ready_event = (state_reg.clk_state == CLK_STARTING)
                     && (state_reg.settle_count == 5'h00) && osc_locked_i;
  // level detect only meaningful while the main clock runs
  assign level_event = (state_reg.clk_state == CLK_RUNNING)
                     && (mic_level_i > state_reg.level_threshold)
                     && (state_reg.level_threshold != 8'h00); // RULE22

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    own_hit_next = 1'b0;
    own_rdata_next = RESET_BYTE;

    // register writes
    if (access_i.write) begin
      case (access_i.addr)
        ADDR_CLOCK_SETUP: begin
          if (!clock_active) begin // RULE15 RULE27
            state_next.clock_setup = access_i.wdata & SETUP_WRITE_MASK; // RULE23
          end
        end
        ADDR_IRQ_MASK: begin
          state_next.irq_mask_reg = access_i.wdata & IRQ_WRITE_MASK;
        end
        ADDR_SYSTEM_ENABLE: begin
          state_next.system_enable_reg = access_i.wdata;
        end
        ADDR_LEVEL_THRESH: begin
          state_next.level_threshold = access_i.wdata;
        end
        default: begin
        end
      endcase
    end

    // clock state machine
    case (state_reg.clk_state)
      CLK_OFF: begin
        state_next.clock_en = 1'b0;
        state_next.audio_reset = 1'b1; // RULE20
        if (access_i.write && access_i.addr == ADDR_COMMAND
            && access_i.wdata == CMD_CLOCK_START) begin // RULE13
          state_next.clk_state = CLK_STARTING;
          state_next.settle_count = SETTLE_COUNT;
          state_next.clock_en = 1'b1;
        end
      end
      CLK_STARTING: begin
        if (state_reg.settle_count != 5'h00) begin
          state_next.settle_count = state_reg.settle_count - 5'h01;
        end
        if (ready_event) begin
          state_next.clk_state = CLK_RUNNING;
          state_next.audio_reset = 1'b0;
        end
      end
      CLK_RUNNING: begin
        state_next.audio_reset = 1'b0;
      end
      default: begin
        state_next.clk_state = CLK_OFF;
      end
    endcase

    // stop command: gate the main clock after a short drain count
    if (clock_active) begin
      if (state_reg.stop_count != 2'h0) begin
        // keep the audio blocks held through the drain, else the running
        // state would release them for a cycle before the clock halts
        state_next.audio_reset = 1'b1; // RULE20
        state_next.stop_count = state_reg.stop_count - 2'h1;
        if (state_reg.stop_count == 2'h1) begin
          state_next.clk_state = CLK_OFF; // RULE18
          state_next.clock_en = 1'b0;
          state_next.audio_reset = 1'b1; // RULE20
        end
      end else if (access_i.write && access_i.addr == ADDR_COMMAND
                   && access_i.wdata == CMD_CLOCK_STOP) begin
        // stop counted in control cycles: two drain cycles at 50MHz end well
        // inside four cycles of the 24.576MHz main clock
        state_next.stop_count = 2'(STOP_MAX_CYCLES - 2); // RULE18 RULE6
        state_next.audio_reset = 1'b1;
      end
    end

    // status read-to-clear on the read edge itself; the read data still show
    // the old value, and a later clear would drop an event landing on that
    // edge unseen; a new event in the same cycle wins
    if (access_i.read && access_i.addr == ADDR_IRQ_STATUS) begin
      state_next.irq_status_reg = RESET_BYTE; // RULE14
    end
    if (ready_event) begin
      state_next.irq_status_reg[POS_IRQ_CLK_READY] = 1'b1; // RULE14
    end
    if (level_event) begin
      state_next.irq_status_reg[POS_IRQ_LEVEL] = 1'b1; // RULE22
    end

    // readback of own registers
    case (access_i.addr)
      ADDR_IRQ_STATUS: begin
        own_hit_next = 1'b1;
        own_rdata_next = state_reg.irq_status_reg;
      end
      ADDR_IRQ_MASK: begin
        own_hit_next = 1'b1;
        own_rdata_next = state_reg.irq_mask_reg;
      end
      ADDR_CLOCK_SETUP: begin
        own_hit_next = 1'b1;
        own_rdata_next = state_reg.clock_setup;
      end
      ADDR_SYSTEM_ENABLE: begin
        own_hit_next = 1'b1;
        own_rdata_next = state_reg.system_enable_reg;
      end
      ADDR_COMMAND: begin
        own_hit_next = 1'b1;
        own_rdata_next = {7'h00, clock_active};
      end
      ADDR_LEVEL_THRESH: begin
        own_hit_next = 1'b1;
        own_rdata_next = state_reg.level_threshold;
      end
      default: begin
        own_hit_next = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_any) begin // RULE1
      state_reg.clk_state         <= CLK_OFF; // RULE7
      state_reg.settle_count      <= 5'h00;
      state_reg.stop_count        <= 2'h0;
      state_reg.clock_setup       <= RESET_BYTE;
      state_reg.irq_status_reg    <= RESET_BYTE;
      state_reg.irq_mask_reg      <= RESET_BYTE;
      state_reg.system_enable_reg <= RESET_BYTE;
      state_reg.level_threshold   <= RESET_BYTE;
      state_reg.clock_en          <= 1'b0;
      state_reg.audio_reset       <= 1'b1;
      own_rdata_reg               <= RESET_BYTE;
      own_hit_reg                 <= 1'b0;
    end else begin
      state_reg     <= state_next;
      own_rdata_reg <= own_rdata_next;
      own_hit_reg   <= own_hit_next;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // read data one cycle after the address; unmapped addresses up to 0x0F read zero
  assign rdata_o = own_hit_reg ? own_rdata_reg : bank_rdata;

  // clock steering towards the analogue generator
  always_comb begin
    clock_cfg_o.main_clock_en       = state_reg.clock_en;
    clock_cfg_o.use_osc_out         = state_reg.clock_setup[POS_MAIN_SOURCE]; // RULE8
    clock_cfg_o.loop_closed         = state_reg.clock_setup[POS_LOOP_MODE]; // RULE25
    clock_cfg_o.loop_ref_frame_sync = state_reg.clock_setup[POS_LOOP_REF]; // RULE24
    clock_cfg_o.pre_divider         = state_reg.clock_setup[POS_PRE_DIVIDER_HI:POS_PRE_DIVIDER_LO];
    clock_cfg_o.rate_select         = state_reg.clock_setup[POS_RATE_HI:POS_RATE_LO];
    clock_cfg_o.ref_divide_value    = divide_ratio({
      bank_words[ADDR_REF_DIV_HIGH[3:0]][4:0],
      bank_words[ADDR_REF_DIV_LOW[3:0]]}); // RULE26
    clock_cfg_o.feedback_divide_value = divide_ratio({
      bank_words[ADDR_FB_DIV_HIGH[3:0]][4:0],
      bank_words[ADDR_FB_DIV_LOW[3:0]]}); // RULE26
    clock_cfg_o.loop_tuning         = bank_words[ADDR_LOOP_TUNING[3:0]];
  end

  // audio sub-blocks stay in reset whenever the main clock is not running
  assign audio_reset_o  = state_reg.audio_reset | reset_any; // RULE20 RULE4
  assign device_reset_o = reset_any;

  // open-drain interrupt: pull low when any masked flag is set
  // the pin value never changes, only the enable, so a shared pull-up works
  assign irq_low_o    = 1'b0;
  assign irq_low_oe_o = |(state_reg.irq_status_reg
                          & state_reg.irq_mask_reg); // RULE12

endmodule // main_clock_ctrl

// *** verilog/reg_bank.sv ***
`timescale 1ns/1ps
// small byte register memory, read data comes from a register
module reg_bank
  import clock_reset_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // write port
  input  wire logic       we_i,
  input  wire logic [3:0] waddr_i,
  input  wire logic [7:0] wdata_i,
  // read port
  input  wire logic [3:0] raddr_i,
  output logic      [7:0] rdata_o,
  // all words, for steering logic
  output logic [15:0][7:0] words_o
);

  typedef struct packed {
    logic [15:0][7:0] mem;
    logic [7:0]       rdata;
  } bank_state_s;

  bank_state_s state_reg;
  bank_state_s state_next;

  // write then registered read
  always_comb begin
    state_next = state_reg;
    if (we_i) begin
      state_next.mem[waddr_i] = wdata_i;
    end
    state_next.rdata = state_reg.mem[raddr_i];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign words_o = state_reg.mem;

endmodule // reg_bank
